//--- src/tssio_top.sv
/*
 * Signalling I/O module of a transfer switch controller: two field inputs
 * and two output contacts, each mapped to a selectable function, reached
 * by the controller over a classic Wishbone slave.
 * Assumes field pins are asynchronous and controller signals share ref_clk.
 */
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
// What this block does
// - Two inputs, two contacts, each configured independently
// - Up to three instances, variant identity strapped
// - Menus only when powered, bus enabled, detected
// - Emergency stop drives switch to centre off
// - Emergency stop disables automatic mode
// - On-load test toggles on polarity-selected edge
// - Off-load test toggles, same edge rule
// - Inhibit blocks control, delay writes, tests, generator start
// - Manual retransfer blocks return to priority
// - Priority inputs select first or second source
// - Inhibit transfer blocks leaving priority source
// - Bypass ends any running delay now
// - Remote to first; off overrides it
// - Reset alarm clears all four switch failures
// - Mode toggle flips auto/local on edge only
// - Alarm output: any alarm or auto disabled
// - Position outputs follow first, off, second
// - Pre-transfer signal first, transfer held for delay
// - Signal held post-transfer delay, then released
// - On-load test transfers load; off-load does not
`timescale 1ns/100ps
`default_nettype none
module tssio_top #(
	parameter int DLY_W = 16 // Width of pre/post delay counters
) (
	// Clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    reset,
	// Wishbone slave
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [7:0]              wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output var  logic [31:0]             wb_dat_o,
	output var  logic                    wb_ack_o,
	// Field and slot pins
	input  wire logic [1:0]              contact_closed,
	input  wire logic [1:0]              variant_strap,
	input  wire logic                    module_powered,
	input  wire logic                    slot_detect,
	output var  logic [1:0]              relay_on,
	// Controller side
	input  wire tssio_pkg::tssio_ctl_in_t  ctl_in,
	output var  tssio_pkg::tssio_ctl_out_t ctl_out
);
	import tssio_pkg::*;
	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (DLY_W < 1 || DLY_W > 32)
	begin : g_chk
		$error("DLY_W must be 1..32");
	end
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [31:0]      in_cfg_r;       // Input function map
	logic [31:0]      out_cfg_r;      // Output function map
	logic             bus_en_r;       // Module bus enable
	logic [DLY_W-1:0] pre_dly_r;      // Pre-transfer delay
	logic [DLY_W-1:0] post_dly_r;     // Post-transfer delay
	logic [3:0]       alarm_r;        // Sticky switch failures
	logic [1:0]       in_s1_r;        // Contact sync stage 1
	logic [1:0]       in_s2_r;        // Contact sync stage 2
	logic [3:0]       pin_s1_r;       // Strap/power/slot stage 1
	logic [3:0]       pin_s2_r;       // Strap/power/slot stage 2
	logic [1:0]       act_d_r;        // Last synchronised contact level
	logic [1:0]       variant_r;      // Captured variant identity
	logic [1:0]       settle_r;       // Strap capture counter
	logic             auto_r;         // Automatic mode
	logic             test_on_r;      // On-load test running
	logic             test_off_r;     // Off-load test running
	logic [DLY_W-1:0] cnt_r;          // Delay counter
	tssio_pt_state_t  pt_r;           // Pre-transfer sequencer
	tssio_pt_state_t  pt_nxt;         // Next sequencer state
	logic [1:0]       act;            // Input logical state
	logic [1:0]       rise;           // Input activation edge
	logic [15:0]      lvl_hot [2];    // Level per function, per input
	logic [15:0]      edg_hot [2];    // Edge per function, per input
	logic [15:0]      lvl;            // Level per function
	logic [15:0]      edg;            // Edge per function
	logic [7:0]       out_hot [2];    // Output source per function
	logic [1:0]       out_act;        // Output logical state
	logic [7:0]       out_src;        // State of each output function
	logic             req;            // New bus request
	logic             wr;             // Write takes effect
	logic [31:0]      wmask;          // Byte-lane mask
	logic [31:0]      rd_data;        // Read mux
	logic             alarm_any;      // Any alarm present
	logic             auto_dis;       // Automatic operation disabled
	logic             dly_done;       // Running delay has elapsed
	logic [3:0]       alarm_clr;      // Alarm bits cleared this cycle

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Two flops on every asynchronous pin
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			in_s1_r  <= 2'h0;
			in_s2_r  <= 2'h0;
			pin_s1_r <= 4'h0;
			pin_s2_r <= 4'h0;
			act_d_r  <= 2'h0;
		end
		else
		begin
			in_s1_r  <= contact_closed;
			in_s2_r  <= in_s1_r;
			pin_s1_r <= {variant_strap, module_powered, slot_detect};
			pin_s2_r <= pin_s1_r;
			act_d_r  <= in_s2_r; // Contact history for edge detect
		end
	end

	// Strap caught once synchronisers have settled
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			settle_r  <= 2'h0;
			variant_r <= 2'h0;
		end
		else if (settle_r != 2'(TSSIO_SYNC_SETTLE))
		begin
			settle_r  <= settle_r + 2'h1;
			variant_r <= pin_s2_r[3:2];
		end
	end

	// ------------------------------------------------------------
	// Per-channel decode
	// ------------------------------------------------------------
	for (genvar i = 0; i < 2; i++)
	begin : g_ch
		localparam int B = i * TSSIO_CH_STRIDE;
		logic [TSSIO_IN_FN_W-1:0]  in_fn;
		logic [TSSIO_OUT_FN_W-1:0] out_fn;
		assign in_fn  = in_cfg_r[B +: TSSIO_IN_FN_W];
		assign out_fn = out_cfg_r[B +: TSSIO_OUT_FN_W];
		// NC polarity inverts the contact
		assign act[i]  = in_s2_r[i] ^ in_cfg_r[B + TSSIO_IN_POL_BIT];
		// Rise is close for NO, open for NC; a polarity write is no edge
		assign rise[i] = act[i]
			& ~(act_d_r[i] ^ in_cfg_r[B + TSSIO_IN_POL_BIT]);
		assign lvl_hot[i] = act[i] ? (16'h0001 << in_fn) : 16'h0000;
		assign edg_hot[i] = rise[i] ? (16'h0001 << in_fn) : 16'h0000;
		assign out_hot[i] = out_src & (8'h01 << out_fn);
		// No-function code never reaches a source
		assign out_act[i] = |out_hot[i];
	end
	assign lvl = lvl_hot[0] | lvl_hot[1];
	assign edg = edg_hot[0] | edg_hot[1];

	// ------------------------------------------------------------
	// Wishbone slave
	// ------------------------------------------------------------
	assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// One ack per request, dropped next cycle; read data taken with it
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			wb_ack_o <= 1'h0;
			wb_dat_o <= 32'h0;
		end
		else
		begin
			wb_ack_o <= req;
			if (req)
				wb_dat_o <= rd_data;
		end
	end

	// Read mux; unmapped reads as zero
	always_comb
	begin
		if (wb_adr_i == TSSIO_OFF_IN_CFG)
			rd_data = in_cfg_r;
		else if (wb_adr_i == TSSIO_OFF_OUT_CFG)
			rd_data = out_cfg_r;
		else if (wb_adr_i == TSSIO_OFF_CTRL)
			rd_data = {31'h0, bus_en_r};
		else if (wb_adr_i == TSSIO_OFF_STATUS)
			rd_data = {18'h0, pt_r, variant_r, ctl_out.menu_en, auto_r,
				test_on_r, test_off_r, relay_on, act};
		else if (wb_adr_i == TSSIO_OFF_ALARM)
			rd_data = {28'h0, alarm_r};
		else if (wb_adr_i == TSSIO_OFF_PRE_DLY)
			rd_data = 32'(pre_dly_r);
		else if (wb_adr_i == TSSIO_OFF_POST_DLY)
			rd_data = 32'(post_dly_r);
		else
			rd_data = 32'h0;
	end

	// Register writes; switch delays frozen while inhibit is active
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			in_cfg_r  <= TSSIO_RST_IN_CFG;
			out_cfg_r <= TSSIO_RST_OUT_CFG;
			bus_en_r  <= TSSIO_RST_BUS_EN;
			pre_dly_r <= '0;
			post_dly_r <= '0;
		end
		else if (wr)
		begin
			if (wb_adr_i == TSSIO_OFF_IN_CFG)
				in_cfg_r <= (in_cfg_r & ~wmask) | (wb_dat_i & wmask);
			else if (wb_adr_i == TSSIO_OFF_OUT_CFG)
				out_cfg_r <= (out_cfg_r & ~wmask) | (wb_dat_i & wmask);
			else if (wb_adr_i == TSSIO_OFF_CTRL && wb_sel_i[0])
				bus_en_r <= wb_dat_i[0];
			else if (wb_adr_i == TSSIO_OFF_PRE_DLY && !lvl[IN_INH_AUTO])
				pre_dly_r <= DLY_W'((32'(pre_dly_r) & ~wmask) | (wb_dat_i & wmask));
			else if (wb_adr_i == TSSIO_OFF_POST_DLY && !lvl[IN_INH_AUTO])
				post_dly_r <= DLY_W'((32'(post_dly_r) & ~wmask) | (wb_dat_i & wmask));
		end
	end

	// ------------------------------------------------------------
	// Alarms
	// ------------------------------------------------------------
	// Reset-alarm edge or software write-one clears
	assign alarm_clr = (edg[IN_ALM_RST] ? 4'hF : 4'h0) |
		((wr && wb_adr_i == TSSIO_OFF_ALARM && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0);

	// Sticky failures; a new failure beats a clear
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			alarm_r <= 4'h0;
		else
			alarm_r <= (alarm_r & ~alarm_clr) | ctl_in.fail;
	end

	assign alarm_any = (|alarm_r) | ctl_in.alarm_ext;
	assign auto_dis  = ~auto_r | lvl[IN_ESTOP] | lvl[IN_INH_AUTO] | ctl_in.auto_off;

	// ------------------------------------------------------------
	// Mode and tests
	// ------------------------------------------------------------
	// Auto/local toggle; emergency stop forces local
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			auto_r <= TSSIO_RST_AUTO;
		else if (lvl[IN_ESTOP])
			auto_r <= 1'h0;
		else if (edg[IN_MODE_TGL])
			auto_r <= ~auto_r;
	end

	// Test start/stop on edge; inhibit stops and blocks
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			test_on_r  <= 1'h0;
			test_off_r <= 1'h0;
		end
		else if (lvl[IN_INH_AUTO] || lvl[IN_ESTOP])
		begin
			test_on_r  <= 1'h0;
			test_off_r <= 1'h0;
		end
		else
		begin
			if (edg[IN_TEST_ON])
				test_on_r <= ~test_on_r;
			if (edg[IN_TEST_OFF])
				test_off_r <= ~test_off_r;
		end
	end

	// ------------------------------------------------------------
	// Pre-transfer sequencer
	// ------------------------------------------------------------
	// Delay ends on count or on bypass
	assign dly_done = edg[IN_BYPASS] ||
		(pt_r == PT_PRE && cnt_r >= pre_dly_r) ||
		(pt_r == PT_POST && cnt_r >= post_dly_r);

	// Next state
	always_comb
	begin
		pt_nxt = pt_r;
		case (pt_r)
			PT_IDLE:
				if (ctl_in.xfer_req && !lvl[IN_INH_AUTO])
					pt_nxt = PT_PRE;
			PT_PRE:
				if (dly_done)
					pt_nxt = PT_XFER;
			PT_XFER:
				if (ctl_in.xfer_done)
					pt_nxt = PT_POST;
			PT_POST:
				if (dly_done)
					pt_nxt = PT_IDLE;
			default:
				pt_nxt = PT_IDLE;
		endcase
	end

	// State and delay counter
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			pt_r  <= PT_IDLE;
			cnt_r <= '0;
		end
		else
		begin
			pt_r <= pt_nxt;
			if (pt_nxt != pt_r)
				cnt_r <= '0;
			else if (cnt_r != '1)
				cnt_r <= cnt_r + DLY_W'(1);
		end
	end

	// ------------------------------------------------------------
	// Output function sources
	// ------------------------------------------------------------
	always_comb
	begin
		out_src               = 8'h00;
		out_src[OUT_ALARM]    = alarm_any | auto_dis;
		out_src[OUT_AT_1ST]   = ctl_in.pos == POS_1ST;
		out_src[OUT_AT_OFF]   = ctl_in.pos == POS_OFF;
		out_src[OUT_AT_2ND]   = ctl_in.pos == POS_2ND;
		out_src[OUT_PRE_XFER] = pt_r != PT_IDLE;
	end

	// Relay drive; NC contact closed when inactive
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			relay_on <= 2'h0;
		else
			relay_on <= out_act ^ {out_cfg_r[TSSIO_CH_STRIDE + TSSIO_OUT_POL_BIT],
				out_cfg_r[TSSIO_OUT_POL_BIT]};
	end

	// ------------------------------------------------------------
	// Controller commands
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			ctl_out <= '0;
		else
		begin
			ctl_out.estop      <= lvl[IN_ESTOP];
			ctl_out.auto_dis   <= auto_dis;
			ctl_out.ctl_block  <= lvl[IN_INH_AUTO];
			ctl_out.gen_blk    <= lvl[IN_INH_AUTO];
			ctl_out.man_retx   <= lvl[IN_MAN_RETX];
			ctl_out.prio_valid <= lvl[IN_PRIO_1ST] | lvl[IN_PRIO_2ND];
			ctl_out.prio_2nd   <= lvl[IN_PRIO_2ND] & ~lvl[IN_PRIO_1ST];
			ctl_out.inh_xfer   <= lvl[IN_INH_XFER];
			ctl_out.bypass     <= edg[IN_BYPASS];
			ctl_out.rc_off     <= lvl[IN_RC_OFF] & ~lvl[IN_INH_AUTO];
			ctl_out.rc_1st     <= lvl[IN_RC_1ST] & ~lvl[IN_RC_OFF]
				& ~lvl[IN_INH_AUTO];
			ctl_out.rc_2nd     <= lvl[IN_RC_2ND] & ~lvl[IN_RC_OFF]
				& ~lvl[IN_RC_1ST] & ~lvl[IN_INH_AUTO];
			ctl_out.test_run   <= test_on_r | test_off_r;
			ctl_out.test_xfer  <= test_on_r;
			ctl_out.xfer_go    <= pt_r == PT_XFER;
			ctl_out.menu_en    <= pin_s2_r[1] & bus_en_r & pin_s2_r[0];
		end
	end

endmodule : tssio_top

`default_nettype wire

//--- src/tssio_pkg.sv
/*
 * Shared constants and types for the transfer switch signalling I/O block:
 * register offsets, field layouts, reset values, function codes, FSM states
 * and the structs that carry the controller-side signals.
 * Assumes a single clock domain and a classic Wishbone slave with 32-bit data.
 */
package tssio_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] TSSIO_OFF_IN_CFG   = 8'h00; // Input functions, polarity
	localparam logic [7:0] TSSIO_OFF_OUT_CFG  = 8'h04; // Output functions, polarity
	localparam logic [7:0] TSSIO_OFF_CTRL     = 8'h08; // Module bus enable
	localparam logic [7:0] TSSIO_OFF_STATUS   = 8'h0C; // Live state, read only
	localparam logic [7:0] TSSIO_OFF_ALARM    = 8'h10; // Sticky alarms, write one clears
	localparam logic [7:0] TSSIO_OFF_PRE_DLY  = 8'h14; // Pre-transfer delay, cycles
	localparam logic [7:0] TSSIO_OFF_POST_DLY = 8'h18; // Post-transfer delay, cycles

	// ------------------------------------------------------------
	// Field layout
	// ------------------------------------------------------------
	localparam int TSSIO_CH_STRIDE   = 8;  // Per-channel field spacing
	localparam int TSSIO_IN_FN_W     = 4;  // Input function code width
	localparam int TSSIO_OUT_FN_W    = 3;  // Output function code width
	localparam int TSSIO_IN_POL_BIT  = 4;  // Input NC bit within channel
	localparam int TSSIO_OUT_POL_BIT = 3;  // Output NC bit within channel
	localparam int TSSIO_NUM_ALARM   = 4;  // Open/close fail per source
	localparam int TSSIO_NUM_IN_FN   = 16; // Size of input code space
	localparam int TSSIO_NUM_OUT_FN  = 8;  // Size of output code space

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [31:0] TSSIO_RST_IN_CFG  = 32'h0000_0000; // No function, NO
	localparam logic [31:0] TSSIO_RST_OUT_CFG = 32'h0000_0000; // No function, NO
	localparam logic        TSSIO_RST_BUS_EN  = 1'h1;          // Module bus on
	localparam logic        TSSIO_RST_AUTO    = 1'h1;          // Start in automatic
	localparam int          TSSIO_SYNC_SETTLE = 3;             // Cycles before strap capture

	// ------------------------------------------------------------
	// Input function codes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		IN_NONE      = 4'h0,
		IN_ESTOP     = 4'h1,
		IN_TEST_ON   = 4'h2,
		IN_TEST_OFF  = 4'h3,
		IN_INH_AUTO  = 4'h4,
		IN_MAN_RETX  = 4'h5,
		IN_PRIO_1ST  = 4'h6,
		IN_PRIO_2ND  = 4'h7,
		IN_INH_XFER  = 4'h8,
		IN_BYPASS    = 4'h9,
		IN_RC_1ST    = 4'hA,
		IN_RC_OFF    = 4'hB,
		IN_RC_2ND    = 4'hC,
		IN_ALM_RST   = 4'hD,
		IN_MODE_TGL  = 4'hE
	} tssio_in_fn_t;

	// ------------------------------------------------------------
	// Output function codes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		OUT_NONE     = 3'h0,
		OUT_ALARM    = 3'h1,
		OUT_AT_1ST   = 3'h2,
		OUT_AT_OFF   = 3'h3,
		OUT_AT_2ND   = 3'h4,
		OUT_PRE_XFER = 3'h5
	} tssio_out_fn_t;

	// Switch position reported by the controller
	typedef enum logic [1:0] {
		POS_OFF = 2'h0,
		POS_1ST = 2'h1,
		POS_2ND = 2'h2
	} tssio_pos_t;

	// Pre-transfer sequencer, one-hot
	typedef enum logic [3:0] {
		PT_IDLE = 4'h1,
		PT_PRE  = 4'h2,
		PT_XFER = 4'h4,
		PT_POST = 4'h8
	} tssio_pt_state_t;

	// ------------------------------------------------------------
	// Controller-side carriers
	// ------------------------------------------------------------
	typedef struct packed {
		tssio_pos_t pos;        // Present switch position
		logic       alarm_ext;  // Any other controller alarm
		logic       auto_off;   // Controller-side auto disable
		logic [3:0] fail;       // Open1, close1, open2, close2 fail pulses
		logic       xfer_req;   // Controller wants to transfer
		logic       xfer_done;  // Transfer finished, pulse
	} tssio_ctl_in_t;

	typedef struct packed {
		logic estop;        // Go to centre off
		logic auto_dis;     // Automatic mode disabled
		logic ctl_block;    // Switch operations blocked
		logic gen_blk;      // No generator start on priority loss
		logic man_retx;     // No automatic return to priority
		logic prio_valid;   // Priority set by input
		logic prio_2nd;     // Second source is priority
		logic inh_xfer;     // No transfer away from priority
		logic bypass;       // End running delay, pulse
		logic rc_1st;       // Remote command to first source
		logic rc_off;       // Remote command to off
		logic rc_2nd;       // Remote command to second source
		logic test_run;     // Test sequence running
		logic test_xfer;    // Running test moves the load
		logic xfer_go;      // Transfer may proceed
		logic menu_en;      // Module menus may be shown
	} tssio_ctl_out_t;

endpackage : tssio_pkg

//--- tb/tssio_checker.sv
/* Concurrent checks on the signalling block's ports.
   Assumes binding into tssio_top; one clock, sync reset. */
`timescale 1ns/100ps
`default_nettype none
module tssio_checker (
	// Clock and reset
	input wire logic                      ref_clk,
	input wire logic                      reset,
	// Bus and pins
	input wire logic                      wb_cyc_i,
	input wire logic                      wb_stb_i,
	input wire logic                      wb_ack_o,
	input wire logic                      module_powered,
	input wire logic                      slot_detect,
	input wire logic [1:0]                relay_on,
	// Controller side
	input wire tssio_pkg::tssio_ctl_in_t  ctl_in,
	input wire tssio_pkg::tssio_ctl_out_t ctl_out
);
	import tssio_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Taken request, then a one-cycle ack
	sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
	property p_ack; s_take |=> s_ack; endproperty
	a_ack: assert property (p_ack) else $error("Ack not a single pulse");
	property p_rst; $fell(reset) |-> relay_on == 2'h0 && ctl_out == '0; endproperty
	a_rst: assert property (p_rst) else $error("Outputs not idle after reset");
	property p_estop; ctl_out.estop |-> ctl_out.auto_dis; endproperty
	a_estop: assert property (p_estop) else $error("Stop left auto on");
	// Stop released: automatic mode must stay off
	sequence s_stop_end; ctl_out.estop ##1 !ctl_out.estop; endsequence
	property p_stop; s_stop_end |-> ctl_out.auto_dis; endproperty
	a_stop: assert property (p_stop) else $error("Auto back after stop");
	property p_rc1; ctl_out.rc_1st |-> !ctl_out.rc_off; endproperty
	a_rc1: assert property (p_rc1) else $error("Off did not override first");
	property p_rc2; ctl_out.rc_2nd |-> !ctl_out.rc_off && !ctl_out.rc_1st; endproperty
	a_rc2: assert property (p_rc2) else $error("Second not overridden");
	property p_inh;
		ctl_out.ctl_block [*2] |-> ctl_out.gen_blk && !ctl_out.test_run && !ctl_out.rc_1st;
	endproperty
	a_inh: assert property (p_inh) else $error("Inhibit not blocking");
	property p_onl; ctl_out.test_xfer |-> ctl_out.test_run; endproperty
	a_onl: assert property (p_onl) else $error("Load moved without test");
	property p_prio; ctl_out.prio_2nd |-> ctl_out.prio_valid; endproperty
	a_prio: assert property (p_prio) else $error("Priority flag without valid");
	property p_byp; ctl_out.bypass |=> !ctl_out.bypass; endproperty
	a_byp: assert property (p_byp) else $error("Bypass not a pulse");
	property p_go; ctl_out.xfer_go && ctl_in.xfer_done |-> ##[1:2] !ctl_out.xfer_go; endproperty
	a_go: assert property (p_go) else $error("Go held after done");
	property p_menu; (!module_powered || !slot_detect) [*4] |=> !ctl_out.menu_en; endproperty
	a_menu: assert property (p_menu) else $error("Menu shown without module");
endmodule : tssio_checker
`default_nettype wire

//--- tb/tssio_ctl_model.sv
/* Behavioural switch controller on the block's controller side.
   Assumes the bench pulses kick and fail_inj for one cycle. */
`timescale 1ns/100ps
`default_nettype none
module tssio_ctl_model #(
	parameter int LAT = 4 // Done raised after LAT + 1 cycles of go
) (
	// Clock and reset
	input wire logic                    ref_clk,
	input wire logic                    reset,
	// Bench commands
	input wire logic                    kick,
	input wire logic                    fail_inj,
	// Block side
	input wire logic                    xfer_go,
	output var tssio_pkg::tssio_ctl_in_t ctl_in
);
	import tssio_pkg::*;
	int cnt; // Cycles since go
	// Request, move the switch, report a failure
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			ctl_in <= '0;
			cnt <= 0;
		end
		else
		begin
			ctl_in.fail <= {3'h0, fail_inj};
			ctl_in.xfer_done <= 1'h0;
			if (kick)
				ctl_in.xfer_req <= 1'h1;
			if (!xfer_go)
				cnt <= 0;
			else if (!ctl_in.xfer_done)
				cnt <= cnt + 1;
			if (xfer_go && cnt == LAT)
			begin
				ctl_in.xfer_done <= 1'h1;
				ctl_in.xfer_req <= 1'h0;
				ctl_in.pos <= POS_2ND;
				cnt <= 0;
			end
		end
	end
endmodule : tssio_ctl_model
`default_nettype wire

//--- tb/tb.sv
/* Self-checking bench for the signalling block.
   Assumes the checker and controller model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb;
	import tssio_pkg::*;
	logic           ref_clk, reset, cyc, stb, we, ack, kick, fail_inj, pwr;
	logic [7:0]     adr;
	logic [31:0]    dat, q, rq;
	logic [1:0]     cc, relay;
	tssio_ctl_in_t  ci;
	tssio_ctl_out_t co;
	int             bad_count, cmp_count;
	tssio_top dut (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(q),
		.wb_ack_o(ack), .contact_closed(cc), .variant_strap(2'h1), .module_powered(pwr),
		.slot_detect(1'h1), .relay_on(relay), .ctl_in(ci), .ctl_out(co));
	tssio_ctl_model #(.LAT(4)) u_ctl (.ref_clk(ref_clk), .reset(reset), .kick(kick),
		.fail_inj(fail_inj), .xfer_go(co.xfer_go), .ctl_in(ci));
	initial
	begin
		ref_clk = 1'h0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test();
		$display("Compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : wt
	// Classic single cycle; waits for ack under a bound
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		{cyc, stb, we, adr, dat} <= {1'h1, 1'h1, w, a, d};
		i = 0;
		do
		begin
			@(posedge ref_clk);
			i++;
		end
		while (ack !== 1'h1 && i < 50);
		if (i >= 50)
		begin
			chk(32'h0, 32'h1);
			end_of_test();
		end
		rq = q;
		{cyc, stb} <= 2'h0;
	endtask : wb
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		wb(1'h0, a, 32'h0);
		chk(rq, e);
	endtask : rdc
	task automatic pin(input logic [1:0] v);
		cc <= v;
		wt(5);
	endtask : pin
	task automatic t_reset();
		rdc(TSSIO_OFF_IN_CFG, 32'h0);
		rdc(TSSIO_OFF_OUT_CFG, 32'h0);
		rdc(TSSIO_OFF_CTRL, 32'h1);
		rdc(8'h1C, 32'h0);
		rdc(TSSIO_OFF_STATUS, 32'h05C0);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_alarm();
		wb(1'h1, TSSIO_OFF_OUT_CFG, 32'h1);
		fail_inj <= 1'h1;
		wt(1);
		fail_inj <= 1'h0;
		wt(4);
		chk(32'(relay), 32'h1);
		rdc(TSSIO_OFF_ALARM, 32'h1);
		wb(1'h1, TSSIO_OFF_IN_CFG, 32'hD);
		pin(2'h1);
		rdc(TSSIO_OFF_ALARM, 32'h0);
		chk(32'(relay), 32'h0);
		pin(2'h0);
		$display("t_alarm done");
	endtask : t_alarm
	// Pre-transfer hold and post-transfer release
	task automatic t_xfer();
		int i, n;
		wb(1'h1, TSSIO_OFF_OUT_CFG, 32'h0405);
		wb(1'h1, TSSIO_OFF_PRE_DLY, 32'h3);
		wb(1'h1, TSSIO_OFF_POST_DLY, 32'h4);
		kick <= 1'h1;
		wt(1);
		kick <= 1'h0;
		n = 0;
		for (i = 0; i < 60 && co.xfer_go !== 1'h1; i++)
		begin
			wt(1);
			n += int'(relay[0] === 1'h1);
		end
		chk(32'(n >= 3 && n <= 7), 32'h1);
		for (i = 0; i < 60 && co.xfer_go === 1'h1; i++)
			wt(1);
		for (n = 0; n < 60 && relay[0] === 1'h1; n++)
			wt(1);
		chk(32'(n >= 4 && n <= 8), 32'h1);
		chk(32'(relay), 32'h2);
		$display("t_xfer done");
	endtask : t_xfer
	task automatic t_test();
		wb(1'h1, TSSIO_OFF_IN_CFG, 32'h2);
		pin(2'h1);
		chk(32'({co.test_run, co.test_xfer}), 32'h3);
		pin(2'h0);
		chk(32'({co.test_run, co.test_xfer}), 32'h3);
		pin(2'h1);
		chk(32'({co.test_run, co.test_xfer}), 32'h0);
		wb(1'h1, TSSIO_OFF_IN_CFG, 32'h13);
		pin(2'h0);
		chk(32'({co.test_run, co.test_xfer}), 32'h2);
		$display("t_test done");
	endtask : t_test
	// Remote commands, inhibit, priority, polarity, stop
	task automatic t_remote();
		logic [31:0] cf[10] = '{32'h0B0A, 32'h0B0C, 32'h0A0C, 32'h000C, 32'h0A04, 32'h0007,
			32'h0706, 32'h001A, 32'h0009, 32'h0001};
		logic [5:0]  ex[10] = '{6'h08, 6'h08, 6'h10, 6'h04, 6'h02, 6'h01, 6'h00, 6'h00,
			6'h00, 6'h20};
		for (int i = 0; i < 10; i++)
		begin
			pin(2'h0);
			wb(1'h1, TSSIO_OFF_IN_CFG, cf[i]);
			pin(2'h3);
			chk(32'({co.estop, co.rc_1st, co.rc_off, co.rc_2nd, co.ctl_block, co.prio_2nd}),
				32'(ex[i]));
		end
		$display("t_remote done");
	endtask : t_remote
	// Stop forces local; toggle flips on its edge only
	task automatic t_mode();
		pin(2'h0);
		chk(32'(co.auto_dis), 32'h1);
		wb(1'h1, TSSIO_OFF_IN_CFG, 32'hE);
		pin(2'h1);
		chk(32'(co.auto_dis), 32'h0);
		pin(2'h3);
		chk(32'(co.auto_dis), 32'h0);
		pin(2'h0);
		chk(32'(co.auto_dis), 32'h0);
		pin(2'h1);
		chk(32'(co.auto_dis), 32'h1);
		$display("t_mode done");
	endtask : t_mode
	task automatic t_menu();
		pwr <= 1'h0;
		wt(6);
		chk(32'(co.menu_en), 32'h0);
		pwr <= 1'h1;
		wt(6);
		chk(32'(co.menu_en), 32'h1);
		$display("t_menu done");
	endtask : t_menu
	initial
	begin
		{reset, pwr, cyc, stb, we, kick, fail_inj} = 7'h60;
		{adr, dat, cc, bad_count, cmp_count} = '0;
		wt(4);
		reset <= 1'h0;
		t_reset();
		t_alarm();
		t_xfer();
		t_test();
		t_remote();
		t_mode();
		t_menu();
		end_of_test();
	end
endmodule : tb
bind tssio_top tssio_checker u_chk (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .module_powered(module_powered),
	.slot_detect(slot_detect), .relay_on(relay_on), .ctl_in(ctl_in), .ctl_out(ctl_out));
`default_nettype wire
